// [design/event_count_pulse_measure_timer.sv]
// Six-channel 16-bit event counter / pulse period and width measurement timer with APB slave
// Functional notes
// - Six identical channels 0..5; mode register bits 1:0 pick the mode.
// - Event mode counts pin edges: rising, falling or both, software chosen.
// - Event mode may count the neighbour channel's overflow or underflow instead.
// - Event mode counts down; on underflow reloads, continues and requests interrupt.
// - Loaded value n gives one underflow per n+1 events.
// - Run flag 1 starts counting, 0 stops it, in both modes.
// - Event mode: count register read returns the live counter.
// - Event mode, stopped: count write loads reload register and counter.
// - Event mode, running: count write loads reload only; counter takes it at reload.
// - Measure mode counts up; each effective edge latches count, restarts from zero.
// - Measure mode requests interrupt per effective edge except the first after start.
// - Measure overflow requests interrupt and sets the overflow flag together.
// - Overflow flag clears on mode write in a cycle after the next count tick after set.
// - Measure mode: count register read returns the reload register result.
// - Measure result is undefined until the second effective edge after start.
// - Measure mode ignores count register writes.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.svh"

module event_count_pulse_measure_timer
   import event_timer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [`NUM_CH-1:0] i_timer_input_pin,
   input wire logic i_subclock,
   output logic [`NUM_CH-1:0] o_irq_req
);

   // Register bus state
   chan_cfg_s cfg_ff [`NUM_CH];
   chan_cfg_s nxt_cfg [`NUM_CH];
   logic [`NUM_CH-1:0] run_ff;
   logic [`NUM_CH-1:0] nxt_run;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic err_ff;
   logic nxt_err;
   logic [`NUM_CH-1:0] wr_mode;
   logic [`NUM_CH-1:0] wr_cnt;

   // Channel state
   logic [`CNT_W-1:0] cnt_ff [`NUM_CH];
   logic [`CNT_W-1:0] nxt_cnt [`NUM_CH];
   logic [`CNT_W-1:0] rld_ff [`NUM_CH];
   logic [`CNT_W-1:0] nxt_rld [`NUM_CH];
   logic [`NUM_CH-1:0] ovf_ff;
   logic [`NUM_CH-1:0] nxt_ovf;
   logic [`NUM_CH-1:0] armed_ff;
   logic [`NUM_CH-1:0] nxt_armed;
   logic [`NUM_CH-1:0] seen_ff;
   logic [`NUM_CH-1:0] nxt_seen;
   logic [`NUM_CH-1:0] wrap_ff;
   logic [`NUM_CH-1:0] nxt_wrap;
   logic [`NUM_CH-1:0] irq_ff;
   logic [`NUM_CH-1:0] nxt_irq;

   // Prescaler state
   logic [4:0] div_ff;
   logic [4:0] nxt_div;
   logic [4:0] sub_ff;
   logic [4:0] nxt_sub;
   logic clock_div_one;
   logic clock_div_eight;
   logic clock_div_thirtytwo;
   logic subclock_div_thirtytwo;

   edge_evt_s pin_evt;
   logic [2:0] acc_ch;
   logic [3:0] acc_ofs;
   logic acc_chan_ok;
   logic acc_run_ok;
   logic setup;
   logic access;

   // Pins and subclock cross into the system clock here
   pin_edge_sync u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_pin({i_subclock, i_timer_input_pin}),
      .o_evt(pin_evt)
   );

   // Count sources as one-cycle enables; subclock taps are counted on its rising edges
   always_comb begin
      nxt_div = div_ff + 5'h01;
      nxt_sub = sub_ff;
      if (pin_evt.rise[`NUM_CH]) begin
         nxt_sub = sub_ff + 5'h01;
      end
      clock_div_one = 1'b1;
      clock_div_eight = (div_ff[2:0] == 3'(`DIV8_LAST));
      clock_div_thirtytwo = (div_ff == `DIV32_LAST);
      subclock_div_thirtytwo = pin_evt.rise[`NUM_CH] && (sub_ff == `DIV32_LAST);
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_ff <= 5'h00;
         sub_ff <= 5'h00;
      end else begin
         div_ff <= nxt_div;
         sub_ff <= nxt_sub;
      end
   end

   // APB decode; zero wait states, read data captured in the setup cycle
   always_comb begin
      acc_ch = i_paddr[6:4];
      acc_ofs = i_paddr[3:0];
      acc_chan_ok = !i_paddr[7] && (acc_ch <= `CH_LAST) &&
                    ((acc_ofs == `OFS_MODE) || (acc_ofs == `OFS_COUNT));
      acc_run_ok = (i_paddr == `OFS_RUN);
      setup = i_psel && !i_penable;
      access = i_psel && i_penable;
      o_pready = access;
      o_prdata = rdata_ff;
      o_pslverr = access && err_ff;
   end

   // Write strobes per channel, effective only at the access edge
   always_comb begin
      wr_mode = '0;
      wr_cnt = '0;
      nxt_run = run_ff;
      for (int c = 0; c < `NUM_CH; c++) begin
         nxt_cfg[c] = cfg_ff[c];
         if (access && i_pwrite && acc_chan_ok && (acc_ch == c[2:0])) begin
            wr_mode[c] = (acc_ofs == `OFS_MODE);
            wr_cnt[c] = (acc_ofs == `OFS_COUNT);
         end
         if (wr_mode[c]) begin
            nxt_cfg[c].mode = i_pwdata[`MODE_LSB +: 2];
            nxt_cfg[c].edge_sel = i_pwdata[`EDGE_LSB +: 2];
            nxt_cfg[c].src_nb = i_pwdata[`SRC_BIT];
            nxt_cfg[c].clk_sel = i_pwdata[`CLK_LSB +: 2];
         end
      end
      if (access && i_pwrite && acc_run_ok) begin
         nxt_run = i_pwdata[`NUM_CH-1:0];
      end
   end

   // Read mux: measure mode shows the result, event mode the live count
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_err = err_ff;
      if (setup) begin
         nxt_rdata = 32'h0000_0000;
         nxt_err = !(acc_chan_ok || acc_run_ok);
         if (acc_run_ok) begin
            nxt_rdata[`NUM_CH-1:0] = run_ff;
         end
         for (int c = 0; c < `NUM_CH; c++) begin
            if (acc_chan_ok && (acc_ch == c[2:0])) begin
               if (acc_ofs == `OFS_MODE) begin
                  nxt_rdata[`MODE_LSB +: 2] = cfg_ff[c].mode;
                  nxt_rdata[`EDGE_LSB +: 2] = cfg_ff[c].edge_sel;
                  nxt_rdata[`SRC_BIT] = cfg_ff[c].src_nb;
                  nxt_rdata[`OVF_BIT] = ovf_ff[c];
                  nxt_rdata[`CLK_LSB +: 2] = cfg_ff[c].clk_sel;
               end else if (cfg_ff[c].mode == `MODE_MEASURE) begin
                  nxt_rdata[`CNT_W-1:0] = rld_ff[c];
               end else begin
                  nxt_rdata[`CNT_W-1:0] = cnt_ff[c];
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int c = 0; c < `NUM_CH; c++) begin
            cfg_ff[c] <= `MODE_RST;
         end
         run_ff <= '0;
         rdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else begin
         cfg_ff <= nxt_cfg;
         run_ff <= nxt_run;
         rdata_ff <= nxt_rdata;
         err_ff <= nxt_err;
      end
   end

   // One counter per channel
   for (genvar g = 0; g < `NUM_CH; g++) begin : g_ch
      localparam int NB = (g + `NUM_CH - 1) % `NUM_CH;
      logic tick;
      logic pin_eff;
      logic src_evt;

      // Count tick and effective edge of this channel
      always_comb begin
         unique case (cfg_ff[g].clk_sel)
            `CLK_DIV1: tick = clock_div_one;
            `CLK_DIV8: tick = clock_div_eight;
            `CLK_DIV32: tick = clock_div_thirtytwo;
            `CLK_SUB32: tick = subclock_div_thirtytwo;
         endcase
         // Falling, rising or both; in measure mode both means width measurement
         unique case (cfg_ff[g].edge_sel)
            `EDGE_FALL: pin_eff = pin_evt.fall[g];
            `EDGE_RISE: pin_eff = pin_evt.rise[g];
            `EDGE_BOTH: pin_eff = pin_evt.rise[g] | pin_evt.fall[g];
            default: pin_eff = 1'b0;
         endcase
         // Neighbour event is registered, so no loop forms around the ring
         src_evt = cfg_ff[g].src_nb ? wrap_ff[NB] : pin_eff;
      end

      // Next state of the channel counter
      always_comb begin
         nxt_cnt[g] = cnt_ff[g];
         nxt_rld[g] = rld_ff[g];
         nxt_ovf[g] = ovf_ff[g];
         nxt_armed[g] = armed_ff[g];
         nxt_seen[g] = seen_ff[g] && run_ff[g];
         nxt_wrap[g] = 1'b0;
         nxt_irq[g] = 1'b0;
         // Clear first so that an overflow in the same cycle wins
         if (wr_mode[g] && armed_ff[g]) begin
            nxt_ovf[g] = 1'b0;
            nxt_armed[g] = 1'b0;
         end
         if (ovf_ff[g] && tick) begin
            nxt_armed[g] = 1'b1;
         end
         if (cfg_ff[g].mode == `MODE_EVENT) begin
            if (wr_cnt[g]) begin
               nxt_rld[g] = i_pwdata[`CNT_W-1:0];
               if (!run_ff[g]) begin
                  nxt_cnt[g] = i_pwdata[`CNT_W-1:0];
               end
            end
            if (run_ff[g] && src_evt) begin
               if (cnt_ff[g] == `CNT_RST) begin
                  nxt_cnt[g] = nxt_rld[g];
                  nxt_wrap[g] = 1'b1;
                  nxt_irq[g] = 1'b1;
               end else begin
                  nxt_cnt[g] = cnt_ff[g] - 16'h0001;
               end
            end
         end else if ((cfg_ff[g].mode == `MODE_MEASURE) && run_ff[g]) begin
            // Count register writes fall through untouched here
            if (pin_eff) begin
               nxt_rld[g] = cnt_ff[g];
               nxt_cnt[g] = `CNT_RST;
               nxt_irq[g] = seen_ff[g];
               nxt_seen[g] = 1'b1;
            end else if (tick) begin
               if (cnt_ff[g] == `CNT_MAX) begin
                  nxt_cnt[g] = `CNT_RST;
                  nxt_ovf[g] = 1'b1;
                  nxt_armed[g] = 1'b0;
                  nxt_wrap[g] = 1'b1;
                  nxt_irq[g] = 1'b1;
               end else begin
                  nxt_cnt[g] = cnt_ff[g] + 16'h0001;
               end
            end
         end
      end

      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            cnt_ff[g] <= `CNT_RST;
            rld_ff[g] <= `CNT_RST;
            ovf_ff[g] <= 1'b0;
            armed_ff[g] <= 1'b0;
            seen_ff[g] <= 1'b0;
            wrap_ff[g] <= 1'b0;
            irq_ff[g] <= 1'b0;
         end else begin
            cnt_ff[g] <= nxt_cnt[g];
            rld_ff[g] <= nxt_rld[g];
            ovf_ff[g] <= nxt_ovf[g];
            armed_ff[g] <= nxt_armed[g];
            seen_ff[g] <= nxt_seen[g];
            wrap_ff[g] <= nxt_wrap[g];
            irq_ff[g] <= nxt_irq[g];
         end
      end
   end

   // Interrupt requests are one-cycle pulses for an outside controller
   assign o_irq_req = irq_ff;

endmodule
`default_nettype wire

// [design/event_timer_defines.svh]
// Register offsets, field positions, reset values and divider counts of the timer channels
`ifndef EVENT_TIMER_DEFINES_SVH
`define EVENT_TIMER_DEFINES_SVH

`define NUM_CH 6
`define NUM_SYNC 7
`define CNT_W 16
`define CH_LAST 3'h5
// Byte addresses: channel block i at i*0x10, run register after the blocks
`define OFS_MODE 4'h0
`define OFS_COUNT 4'h4
`define OFS_RUN 8'h60
// Mode register field positions
`define MODE_LSB 0
`define EDGE_LSB 2
`define SRC_BIT 4
`define OVF_BIT 5
`define CLK_LSB 6
// Mode field encodings
`define MODE_EVENT 2'h1
`define MODE_MEASURE 2'h2
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define CLK_DIV1 2'h0
`define CLK_DIV8 2'h1
`define CLK_DIV32 2'h2
`define CLK_SUB32 2'h3
// Reset values and counter maximum
`define CNT_RST 16'h0000
`define CNT_MAX 16'hffff
`define MODE_RST 7'h00
// Prescaler terminal counts
`define DIV8_LAST 5'h07
`define DIV32_LAST 5'h1f

`endif

// [design/event_timer_pkg.sv]
// Types shared by the event counter / pulse measurement timer
package event_timer_pkg;

   // Software configuration of one channel
   typedef struct packed {
      logic [1:0] clk_sel;
      logic src_nb;
      logic [1:0] edge_sel;
      logic [1:0] mode;
   } chan_cfg_s;

   // Edge pulses of synchronised inputs
   typedef struct packed {
      logic [6:0] rise;
      logic [6:0] fall;
   } edge_evt_s;

endpackage

// [design/pin_edge_sync.sv]
// Two-flop synchroniser with edge detection for the timer input pins and subclock
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.svh"

module pin_edge_sync
   import event_timer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [`NUM_SYNC-1:0] i_pin,
   output edge_evt_s o_evt
);

   logic [`NUM_SYNC-1:0] meta_ff;
   logic [`NUM_SYNC-1:0] sync_ff;
   logic [`NUM_SYNC-1:0] prev_ff;
   logic [`NUM_SYNC-1:0] nxt_meta;
   logic [`NUM_SYNC-1:0] nxt_sync;
   logic [`NUM_SYNC-1:0] nxt_prev;

   // Edges are only taken from the second stage, never from the first
   always_comb begin
      nxt_meta = i_pin;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
      o_evt.rise = sync_ff & ~prev_ff;
      o_evt.fall = ~sync_ff & prev_ff;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

endmodule
`default_nettype wire

// [verif/timer_chk_sva.sv]
// Port-level checker for the timer channel block
`timescale 1ns/1ps
`default_nettype none
module timer_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [5:0] o_irq_req
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Zero wait states, so a stalled access would hang software
   ready_access_a: assert property (i_psel && i_penable |-> o_pready)
      else $error("pready missing in access");
   ready_idle_a: assert property (!(i_psel && i_penable) |-> !o_pready)
      else $error("pready outside access");
   err_access_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("pslverr outside access");
   err_unmapped_a: assert property (i_psel && i_penable && (i_paddr > 8'h60 || i_paddr[3])
      |-> o_pslverr) else $error("unmapped address accepted");
   err_mapped_a: assert property (i_psel && i_penable && i_paddr < 8'h60
      && i_paddr[3:0] == 4'h4 |-> !o_pslverr) else $error("count register refused");
   count_width_a: assert property (i_psel && i_penable && !i_pwrite && i_paddr[3:0] == 4'h4
      |-> o_prdata[31:16] == 16'h0000) else $error("count upper bits set");
   irq_pulse_a: assert property (|o_irq_req |=> (o_irq_req & $past(o_irq_req)) == 6'h00)
      else $error("interrupt request longer than one cycle");
   // Read data is captured only in a setup cycle
   idle_data_a: assert property (!i_psel |-> $stable(o_prdata))
      else $error("read data moved while idle");
endmodule
bind event_count_pulse_measure_timer timer_chk timer_chk_i (.i_clk, .i_nrst, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_irq_req);
`default_nettype wire

// [verif/pulse_source.sv]
// External pulse source driving the timer input pins
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
   input wire logic i_clk,
   output logic [5:0] o_pin
);
   // Plain driven levels; the pins act as general I/O inputs, no alternate function
   initial o_pin = 6'h00;
   // Called just after a rising edge; each level must last two clocks or more
   task automatic pulse(input int ch, input int hi, input int lo);
      o_pin[ch] <= 1'b1;
      repeat (hi) @(posedge i_clk);
      o_pin[ch] <= 1'b0;
      repeat (lo) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the event counter and pulse measurement timer
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_defines.svh"
module tb_top;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic subclk = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, serr;
   logic [5:0] pin, irq;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int n, v, h, l;
   int irqs[6], mcnt[6], mrel[6], mirq[6];
   int unsigned seed = 77;
   // Subclock is unrelated in phase to the system clock
   always #50 i_clk = ~i_clk;
   always #1730 subclk = ~subclk;
   event_count_pulse_measure_timer event_count_pulse_measure_timer_i (.i_clk(i_clk),
      .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_timer_input_pin(pin), .i_subclock(subclk), .o_irq_req(irq));
   pulse_source pulse_source_i (.i_clk(i_clk), .o_pin(pin));
   // Count interrupt pulses per channel, and cut a hang short
   always @(posedge i_clk) begin
      for (int k = 0; k < 6; k++) if (irq[k] === 1'b1) irqs[k]++;
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         complete_run();
      end
   end
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Model of one counted event: count down, reload and request on underflow
   function automatic void ev(input int ch);
      if (mcnt[ch] == 0) begin
         mcnt[ch] = mrel[ch];
         mirq[ch]++;
      end else begin
         mcnt[ch]--;
      end
   endfunction
   // One APB transfer; the extra edge at the end keeps back-to-back calls apart
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      // Wait states are taken as they come; only the bench timeout ends a hang
      while (pready !== 1'b1) begin
         @(posedge i_clk);
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_irq(input int ch, input int e);
      n_checks++;
      if (irqs[ch] != e) begin
         err_total++;
         $display("unexpected irq count ch%0d: expected %0d seen %0d", ch, e, irqs[ch]);
      end
   endtask
   task automatic rd_cnt(input int ch, input int e);
      apb(1'b0, 8'(16 * ch) + `OFS_COUNT, 32'h0);
      chk_reg("count", 32'(e), rd);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      apb(1'b0, `OFS_MODE, 32'h0);
      chk_reg("mode", 32'h0, rd);
      apb(1'b0, 8'h68, 32'h0);
      chk_reg("slverr", 32'h1, 32'(serr));
      // Event mode on rising edges, random reload value
      n = int'(xs() % 3) + 1;
      apb(1'b1, `OFS_MODE, 32'h05);
      apb(1'b1, `OFS_COUNT, 32'(n));
      mcnt[0] = n;
      mrel[0] = n;
      rd_cnt(0, n);
      apb(1'b1, `OFS_RUN, 32'h1);
      for (int k = 0; k <= n; k++) begin
         pulse_source_i.pulse(0, 3, 5);
         ev(0);
         rd_cnt(0, mcnt[0]);
      end
      chk_irq(0, mirq[0]);
      // A write while counting only reaches the reload value
      v = int'(xs() % 4) + 2;
      apb(1'b1, `OFS_COUNT, 32'(v));
      mrel[0] = v;
      rd_cnt(0, mcnt[0]);
      repeat (mcnt[0] + 1) begin
         pulse_source_i.pulse(0, 3, 5);
         ev(0);
      end
      rd_cnt(0, v);
      apb(1'b1, `OFS_RUN, 32'h0);
      pulse_source_i.pulse(0, 3, 5);
      rd_cnt(0, mcnt[0]);
      // Falling, rising and both edges, one pulse each
      for (int e = 0; e < 3; e++) begin
         apb(1'b1, `OFS_MODE, 32'(1 + 4 * e));
         apb(1'b1, `OFS_COUNT, 32'h9);
         apb(1'b1, `OFS_RUN, 32'h1);
         pulse_source_i.pulse(0, 3, 5);
         apb(1'b1, `OFS_RUN, 32'h0);
         rd_cnt(0, e == 2 ? 7 : 8);
      end
      // Channel 1 counts the underflows of channel 0
      apb(1'b1, `OFS_MODE, 32'h05);
      apb(1'b1, `OFS_COUNT, 32'h0);
      apb(1'b1, 8'h10, 32'h11);
      apb(1'b1, 8'h14, 32'h3);
      apb(1'b1, `OFS_RUN, 32'h3);
      repeat (2) pulse_source_i.pulse(0, 3, 5);
      rd_cnt(1, 1);
      chk_irq(0, mirq[0] + 2);
      apb(1'b1, `OFS_RUN, 32'h0);
      // Period then width measurement on channel 2, undivided clock
      h = int'(xs() % 8) + 3;
      l = int'(xs() % 8) + 3;
      apb(1'b1, 8'h20, 32'h06);
      apb(1'b1, `OFS_RUN, 32'h4);
      repeat (3) pulse_source_i.pulse(2, h, l);
      chk_irq(2, 2);
      rd_cnt(2, h + l - 1);
      apb(1'b1, 8'h24, 32'h1234);
      rd_cnt(2, h + l - 1);
      apb(1'b1, `OFS_RUN, 32'h0);
      apb(1'b1, 8'h20, 32'h0a);
      apb(1'b1, `OFS_RUN, 32'h4);
      repeat (2) pulse_source_i.pulse(2, h, l);
      rd_cnt(2, h - 1);
      chk_irq(2, 5);
      // Prescaled sources: a period of 16*s+1 clocks spans exactly 16*s clocks of taps
      apb(1'b1, `OFS_RUN, 32'h0);
      for (int s = 1; s < 3; s++) begin
         apb(1'b1, 8'h20, 32'(6 + 64 * s));
         apb(1'b1, `OFS_RUN, 32'h4);
         repeat (2) pulse_source_i.pulse(2, 8 * s + 1, 8 * s);
         rd_cnt(2, 3 - s);
         apb(1'b1, `OFS_RUN, 32'h0);
      end
      chk_irq(2, 7);
      // Overflow: preload near the top while stopped in event mode, then measure
      apb(1'b1, 8'h30, 32'h01);
      apb(1'b1, 8'h34, 32'hfff0);
      apb(1'b1, 8'h30, 32'h06);
      apb(1'b1, `OFS_RUN, 32'h8);
      repeat (40) @(posedge i_clk);
      apb(1'b0, 8'h30, 32'h0);
      chk_reg("overflow flag", 32'h26, rd);
      chk_irq(3, 1);
      // Run flag stays set while the mode write clears the flag
      apb(1'b1, 8'h30, 32'h06);
      apb(1'b0, 8'h30, 32'h0);
      chk_reg("overflow clear", 32'h06, rd);
      complete_run();
   end
endmodule
`default_nettype wire
